// >>> core/fpc_pkg.sv
// Package for the fractional synthesizer channel control block.
// Assumes a single 40 MHz system clock shared by all users of these constants.
package fpc_pkg;

	// System clock
	localparam int unsigned CLK_HZ          = 40_000_000;
	localparam int unsigned CLK_PERIOD_NS   = 25;

	// Band encoding
	typedef enum logic [1:0]
	{
		FPC_BAND_315 = 2'b00,
		FPC_BAND_434 = 2'b01,
		FPC_BAND_868 = 2'b10,
		FPC_BAND_915 = 2'b11
	} fpc_band_t;

	// Configuration field positions (register 0x04 band, 0x25 damping)
	localparam logic [7:0] BAND_REG_ADDR    = 8'h04;
	localparam int unsigned BAND_LSB        = 2;
	localparam logic [7:0] DAMP_REG_ADDR    = 8'h25;
	localparam int unsigned DAMP_LSB        = 4;

	// Reset values
	localparam logic [6:0] INT_RST          = 7'h40;
	localparam logic [20:0] FRAC_RST        = 21'h000000;
	localparam logic [3:0] CAP_RST          = 4'h8;

	// Calibration timing
	localparam logic [5:0] CAL_WINDOW_NOM   = 6'h20;
	localparam int unsigned CAL_SETTLE_NS   = 100;
	localparam int unsigned CAL_SETTLE_CYC  =
		(CAL_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [3:0] CAL_SETTLE_TOP   = 4'(CAL_SETTLE_CYC - 1);
	localparam int unsigned CAP_BITS        = 4;

	// Valid integer ranges per band group
	localparam logic [6:0] INT_LO_MIN       = 7'h0F;
	localparam logic [6:0] INT_LO_MAX       = 7'h2B;
	localparam logic [6:0] INT_HI_MIN       = 7'h36;
	localparam logic [6:0] INT_HI_MAX       = 7'h54;

	// Modulator: fraction doubled plus one over (2^22 - 1)
	localparam int unsigned SDM_W           = 22;
	localparam logic [22:0] SDM_MOD         = 23'h3FFFFF;

	// Calibration state machine
	typedef enum logic [2:0]
	{
		CAL_IDLE   = 3'b000,
		CAL_SETTLE = 3'b001,
		CAL_COUNT  = 3'b010,
		CAL_CMP    = 3'b011,
		CAL_DONE   = 3'b100
	} fpc_cal_state_t;

	// One preconfigured frequency set
	typedef struct packed
	{
		logic [6:0]  int_ratio;
		logic [20:0] frac_ratio;
	} fpc_chan_t;

endpackage

// >>> core/fpc_sdm.sv
// First-order sigma-delta sequencer for the multi-modulus divider.
// Assumes one divider reload per system clock while enabled.
module fpc_sdm
	import fpc_pkg::*;
(
	// Clock and reset
	input  wire logic        core_clk,
	input  wire logic        rst_n,
	// Control
	input  wire logic        run,
	input  wire fpc_chan_t   chan,
	// Divider ratio
	output logic [7:0]       mmd_ratio_q
);

	logic [SDM_W-1:0] acc_q;
	logic [SDM_W-1:0] acc_d;
	logic             carry_d;
	logic [22:0]      sum;

	// Step is 2*frac+1 so the mean ratio is (frac+0.5)/(2^21-0.5)
	always_comb
	begin
		sum = {1'b0, acc_q} + {1'b0, chan.frac_ratio, 1'b1};
		if (sum >= SDM_MOD)
		begin
			acc_d   = SDM_W'(sum - SDM_MOD);
			carry_d = 1'b1;
		end
		else
		begin
			acc_d   = sum[SDM_W-1:0];
			carry_d = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !run)
			acc_q <= '0;
		else
			acc_q <= acc_d;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			mmd_ratio_q <= {1'b0, INT_RST};
		else if (run)
			mmd_ratio_q <= {1'b0, chan.int_ratio} + {7'h00, carry_d};
		else
			mmd_ratio_q <= {1'b0, chan.int_ratio};
	end

endmodule

// >>> core/fpc_channel_ctrl.sv
// Channel selection, band dividers and oscillator auto-calibration of a
// fractional-N synthesizer. Assumes the analog loop, the tuning capacitor
// bank and the divided oscillator pin sit outside; osc_div_pin is async.
//
// How it works
// - Calibration starts on every synthesizer enable
// - Fixed tune; divide by four, eight high
// - Count divided rising edges over window
// - Compare with target; tune before transmitting
// - Damping trim field selects loop resistor
// - Chip rate doubles except for NRZ
// - Band divider one, two or three
// - Oscillator runs 2, 4, 6 times RF
// - Modulator sequences divider ratio per cycle
// - Four sets; transmit command picks one
// - Output is crystal times fractional ratio
// - Band field codes four frequency ranges
module fpc_channel_ctrl
	import fpc_pkg::*;
(
	// Clock and reset
	input  wire logic             core_clk,
	input  wire logic             rst_n,
	// Configuration
	input  wire fpc_band_t        band_select,
	input  wire fpc_chan_t [3:0]  chan_sets,
	input  wire logic [8:0]       cal_target_count,
	input  wire logic [5:0]       cal_window_len,
	input  wire logic [2:0]       damping_trim,
	input  wire logic [3:0]       charge_pump_trim,
	input  wire logic             line_code_nrz,
	// Synthesizer and transmit control
	input  wire logic             synth_enable,
	input  wire logic             tx_cmd_valid,
	input  wire logic [1:0]       tx_cmd_channel,
	input  wire logic             tx_stop,
	// Divided oscillator pin
	input  wire logic             osc_div_pin,
	// Analog controls
	output logic                  cal_fixed_tune_q,
	output logic [3:0]            vco_cap_code_q,
	output logic [2:0]            loop_res_sel_q,
	output logic [1:0]            band_div_q,
	output logic [2:0]            vco_mult_q,
	output logic [7:0]            mmd_ratio_q,
	// Status
	output logic                  cal_busy_q,
	output logic                  cal_done_q,
	output logic [8:0]            cal_count_q,
	output logic [8:0]            cal_target_hint_q,
	output logic                  rf_tx_en_q,
	output logic [1:0]            active_channel_q,
	output logic [1:0]            chips_per_bit_q,
	output logic                  int_range_ok_q,
	output logic                  trim_pair_ok_q
);

	// Recommended charge-pump code for each damping code
	function automatic logic [3:0] cp_for_damp(input logic [2:0] d);
		case (d)
			3'h1:    cp_for_damp = 4'hF;
			3'h2:    cp_for_damp = 4'hC;
			3'h3:    cp_for_damp = 4'h9;
			3'h4:    cp_for_damp = 4'h6;
			3'h5:    cp_for_damp = 4'h4;
			3'h6:    cp_for_damp = 4'h2;
			3'h7:    cp_for_damp = 4'h1;
			default: cp_for_damp = 4'h0;
		endcase
	endfunction

	fpc_cal_state_t state_q;
	logic [2:0]     osc_pipe_q;
	logic [2:0]     pre_cnt_q;
	logic [5:0]     win_cnt_q;
	logic [3:0]     settle_q;
	logic [1:0]     bit_idx_q;
	logic           synth_en_q;
	logic           tx_req_q;
	fpc_chan_t      chan_sel;
	logic           cal_start;
	logic           osc_rise;
	logic [2:0]     pre_top;
	logic           div_edge;
	logic [5:0]     win_top;
	logic [27:0]    ratio_fix;

	assign chan_sel  = chan_sets[active_channel_q];
	assign cal_start = synth_enable && !synth_en_q;
	assign osc_rise  = osc_pipe_q[1] && !osc_pipe_q[2];
	assign pre_top   = band_select[1] ? 3'h7 : 3'h3;
	assign div_edge  = osc_rise && (pre_cnt_q == pre_top);
	assign win_top   = (cal_window_len == 6'h00) ? 6'h00 : cal_window_len - 6'h01;
	assign ratio_fix = {chan_sel.int_ratio, chan_sel.frac_ratio};

	// Two-stage synchroniser, third stage for edge detect
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			osc_pipe_q <= 3'h0;
		else
			osc_pipe_q <= {osc_pipe_q[1:0], osc_div_pin};
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			synth_en_q <= 1'b0;
		else
			synth_en_q <= synth_enable;
	end

	// Calibration sequencer with successive approximation of the cap bank
	always_ff @(posedge core_clk)
	begin
		if (!rst_n || !synth_enable)
		begin
			state_q        <= CAL_IDLE;
			vco_cap_code_q <= CAP_RST;
			bit_idx_q      <= 2'(CAP_BITS - 1);
			settle_q       <= 4'h0;
			win_cnt_q      <= 6'h00;
			pre_cnt_q      <= 3'h0;
			cal_count_q    <= 9'h000;
		end
		else
		begin
			case (state_q)
				CAL_IDLE:
				begin
					if (cal_start)
					begin
						state_q        <= CAL_SETTLE;
						vco_cap_code_q <= CAP_RST;
						bit_idx_q      <= 2'(CAP_BITS - 1);
						settle_q       <= 4'h0;
					end
				end
				CAL_SETTLE:
				begin
					settle_q    <= settle_q + 4'h1;
					win_cnt_q   <= 6'h00;
					pre_cnt_q   <= 3'h0;
					cal_count_q <= 9'h000;
					if (settle_q == CAL_SETTLE_TOP)
						state_q <= CAL_COUNT;
				end
				CAL_COUNT:
				begin
					if (osc_rise)
						pre_cnt_q <= (pre_cnt_q == pre_top) ? 3'h0 : pre_cnt_q + 3'h1;
					if (div_edge && cal_count_q != 9'h1FF)
						cal_count_q <= cal_count_q + 9'h001;
					win_cnt_q <= win_cnt_q + 6'h01;
					if (win_cnt_q == win_top)
						state_q <= CAL_CMP;
				end
				CAL_CMP:
				begin
					// Too slow: remove the trial capacitance
					if (cal_count_q < cal_target_count)
						vco_cap_code_q[bit_idx_q] <= 1'b0;
					settle_q <= 4'h0;
					if (bit_idx_q == 2'h0)
						state_q <= CAL_DONE;
					else
					begin
						vco_cap_code_q[bit_idx_q - 2'h1] <= 1'b1;
						bit_idx_q <= bit_idx_q - 2'h1;
						state_q   <= CAL_SETTLE;
					end
				end
				CAL_DONE:
					state_q <= CAL_DONE;
				default:
					state_q <= CAL_IDLE;
			endcase
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			cal_fixed_tune_q <= 1'b0;
			cal_busy_q       <= 1'b0;
			cal_done_q       <= 1'b0;
		end
		else
		begin
			cal_fixed_tune_q <= synth_enable &&
				(state_q inside {CAL_SETTLE, CAL_COUNT});
			cal_busy_q       <= synth_enable && !(state_q inside {CAL_IDLE, CAL_DONE});
			cal_done_q       <= (state_q == CAL_DONE) && synth_enable;
		end
	end

	// Transmit command: channel pick and request, set wins over stop
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			active_channel_q <= 2'h0;
		else if (tx_cmd_valid)
			active_channel_q <= tx_cmd_channel;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			tx_req_q <= 1'b0;
		else if (tx_cmd_valid)
			tx_req_q <= 1'b1;
		else if (tx_stop)
			tx_req_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			rf_tx_en_q <= 1'b0;
		else
			rf_tx_en_q <= tx_req_q && cal_done_q && !tx_stop;
	end

	// Band dividers and multiplication factor
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			band_div_q <= 2'h3;
			vco_mult_q <= 3'h6;
		end
		else
		begin
			case (band_select)
				FPC_BAND_315: {band_div_q, vco_mult_q} <= {2'h3, 3'h6};
				FPC_BAND_434: {band_div_q, vco_mult_q} <= {2'h2, 3'h4};
				default:      {band_div_q, vco_mult_q} <= {2'h1, 3'h2};
			endcase
		end
	end

	// Trims, chip rate and range checks
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
		begin
			loop_res_sel_q  <= 3'h0;
			chips_per_bit_q <= 2'h1;
			int_range_ok_q  <= 1'b0;
			trim_pair_ok_q  <= 1'b0;
		end
		else
		begin
			loop_res_sel_q  <= damping_trim;
			chips_per_bit_q <= line_code_nrz ? 2'h1 : 2'h2;
			trim_pair_ok_q  <= (damping_trim != 3'h0) &&
				(charge_pump_trim == cp_for_damp(damping_trim));
			if (band_select[1])
				int_range_ok_q <= (chan_sel.int_ratio >= INT_HI_MIN) &&
					(chan_sel.int_ratio <= INT_HI_MAX);
			else
				int_range_ok_q <= !chan_sel.int_ratio[6] &&
					(chan_sel.int_ratio >= INT_LO_MIN) &&
					(chan_sel.int_ratio <= INT_LO_MAX);
		end
	end

	// Expected count for a 32-cycle window from the active set
	always_ff @(posedge core_clk)
	begin
		if (!rst_n)
			cal_target_hint_q <= 9'h000;
		else if (band_select[1])
			cal_target_hint_q <= ratio_fix[27:19];
		else
			cal_target_hint_q <= ratio_fix[26:18];
	end

	fpc_sdm u_sdm
	(
		.core_clk    (core_clk),
		.rst_n       (rst_n),
		.run         (synth_enable),
		.chan        (chan_sel),
		.mmd_ratio_q (mmd_ratio_q)
	);

endmodule

// >>> testbench/fpc_channel_ctrl_monitor.sv
// Checker for the channel control block outputs.
// Assumes binding to fpc_channel_ctrl; one clock, sync reset.
module fpc_channel_ctrl_monitor
	import fpc_pkg::*;
(
	// Clock and reset
	input wire logic       core_clk,
	input wire logic       rst_n,
	// Watched inputs
	input wire fpc_band_t  band_select,
	input wire logic [2:0] damping_trim,
	input wire logic       line_code_nrz,
	input wire logic       synth_enable,
	input wire logic       tx_cmd_valid,
	input wire logic       tx_stop,
	// Watched outputs
	input wire logic       cal_fixed_tune_q,
	input wire logic [2:0] loop_res_sel_q,
	input wire logic [1:0] band_div_q,
	input wire logic [2:0] vco_mult_q,
	input wire logic       cal_busy_q,
	input wire logic       cal_done_q,
	input wire logic       rf_tx_en_q,
	input wire logic [1:0] chips_per_bit_q
);
	timeunit 1ns;
	timeprecision 1ps;

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_n);

	sequence s_start;
		$rose(synth_enable) && !cal_busy_q && !cal_done_q;
	endsequence
	sequence s_cmd;
		tx_cmd_valid && cal_done_q && synth_enable;
	endsequence

	AST_CAL_START: assert property (s_start ##1 synth_enable |-> ##1
		cal_busy_q && cal_fixed_tune_q) else $error("cal start");
	AST_CAL_END: assert property ($rose(cal_busy_q) |->
		##[1:200] (cal_done_q || !synth_enable)) else $error("cal end");
	AST_CAL_DROP: assert property (!synth_enable ##1 !synth_enable |->
		!cal_done_q && !cal_busy_q) else $error("cal abort");
	AST_TX_GATE: assert property (rf_tx_en_q |-> $past(cal_done_q))
		else $error("tx early");
	AST_TX_LAT: assert property (s_cmd ##1 (synth_enable && !tx_stop)
		|=> rf_tx_en_q) else $error("tx late");
	AST_TX_STOP: assert property (rf_tx_en_q && tx_stop && !tx_cmd_valid
		&& !$past(tx_cmd_valid) |=> !rf_tx_en_q) else $error("tx stop");
	AST_DAMP: assert property ($past(rst_n) |->
		loop_res_sel_q == $past(damping_trim)) else $error("damping");
	AST_BAND_DIV: assert property ($past(rst_n) && $stable(band_select)
		|-> band_div_q == (band_select[1] ? 2'h1 : band_select[0] ? 2'h2 : 2'h3))
		else $error("band div");
	AST_MULT: assert property ($past(rst_n) && $stable(band_select)
		|-> vco_mult_q == (band_select[1] ? 3'h2 : band_select[0] ? 3'h4 : 3'h6))
		else $error("vco mult");
	AST_CHIPS: assert property ($past(rst_n) && $stable(line_code_nrz)
		|-> chips_per_bit_q == (line_code_nrz ? 2'h1 : 2'h2)) else $error("chips");
endmodule

bind fpc_channel_ctrl fpc_channel_ctrl_monitor u_fpc_channel_ctrl_monitor (.*);

// >>> testbench/test_fpc_channel_ctrl.sv
// Self-checking bench for fpc_channel_ctrl.
// Assumes the monitor is bound; the bench drives every port.
module test_fpc_channel_ctrl
	import fpc_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed
	{
		logic [1:0] b;
		logic       nrz;
		logic [2:0] tr;
		logic [3:0] cp;
		logic [6:0] ir;
		logic [1:0] dv;
		logic [2:0] ml;
		logic       ok;
		logic       pr;
	} fpc_row_t;

	fpc_row_t rows [8] = '{
		'{2'h0, 1'h1, 3'h1, 4'hF, 7'h0F, 2'h3, 3'h6, 1'h1, 1'h1},
		'{2'h1, 1'h0, 3'h2, 4'hC, 7'h2B, 2'h2, 3'h4, 1'h1, 1'h1},
		'{2'h2, 1'h0, 3'h0, 4'hF, 7'h36, 2'h1, 3'h2, 1'h1, 1'h0},
		'{2'h3, 1'h1, 3'h7, 4'h1, 7'h54, 2'h1, 3'h2, 1'h1, 1'h1},
		'{2'h0, 1'h0, 3'h3, 4'h8, 7'h2C, 2'h3, 3'h6, 1'h0, 1'h0},
		'{2'h2, 1'h1, 3'h4, 4'h6, 7'h35, 2'h1, 3'h2, 1'h0, 1'h1},
		'{2'h3, 1'h0, 3'h5, 4'h4, 7'h55, 2'h1, 3'h2, 1'h0, 1'h1},
		'{2'h1, 1'h1, 3'h6, 4'h2, 7'h0E, 2'h2, 3'h4, 1'h0, 1'h1}};

	logic            core_clk = 1'b0;
	logic            rst_n, line_code_nrz, synth_enable;
	logic            tx_cmd_valid, tx_stop, osc_div_pin;
	fpc_band_t       band_select;
	fpc_chan_t [3:0] chan_sets;
	logic [8:0]      cal_target_count, cal_count_q, cal_target_hint_q;
	logic [5:0]      cal_window_len;
	logic [2:0]      damping_trim, loop_res_sel_q, vco_mult_q;
	logic [3:0]      charge_pump_trim, vco_cap_code_q;
	logic [1:0]      tx_cmd_channel, band_div_q, active_channel_q, chips_per_bit_q;
	logic            cal_fixed_tune_q, cal_busy_q, cal_done_q, rf_tx_en_q;
	logic            int_range_ok_q, trim_pair_ok_q;
	logic [7:0]      mmd_ratio_q;
	int              n_mismatch = 0;
	int              compares = 0;

	fpc_channel_ctrl u_fpc_channel_ctrl (.*);

	always #12.5 core_clk = ~core_clk;
	// Free-running divided oscillator, unrelated phase
	always #30 osc_div_pin = ~osc_div_pin;

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic cyc(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	task automatic wait_done();
		int i;
		for (i = 0; i < 400 && cal_done_q !== 1'b1; i++)
			cyc(1);
		if (i == 400)
		begin
			n_mismatch++;
			summarize();
		end
	endtask

	task automatic cal(input fpc_band_t b, input logic [8:0] t, input logic [3:0] cap,
		input logic [8:0] lo, input logic [8:0] hi);
		band_select = b;
		cal_target_count = t;
		synth_enable = 1'b0;
		cyc(2);
		synth_enable = 1'b1;
		wait_done();
		chk(vco_cap_code_q, cap);
		chk(cal_count_q >= lo && cal_count_q <= hi, 1'h1);
	endtask

	initial
	begin
		int k;
		rst_n = 1'b0;
		band_select = FPC_BAND_315;
		chan_sets = '0;
		cal_target_count = 9'h000;
		cal_window_len = CAL_WINDOW_NOM;
		damping_trim = 3'h1;
		charge_pump_trim = 4'hF;
		line_code_nrz = 1'b1;
		synth_enable = 1'b0;
		tx_cmd_valid = 1'b0;
		tx_cmd_channel = 2'h0;
		tx_stop = 1'b0;
		osc_div_pin = 1'b0;
		cyc(12);
		chk({band_div_q, vco_mult_q, mmd_ratio_q, vco_cap_code_q, chips_per_bit_q,
			cal_done_q, rf_tx_en_q}, {2'h3, 3'h6, 8'h40, 4'h8, 2'h1, 2'h0});
		rst_n = 1'b1;
		cyc(3);
		foreach (rows[i])
		begin
			band_select = fpc_band_t'(rows[i].b);
			line_code_nrz = rows[i].nrz;
			damping_trim = rows[i].tr;
			charge_pump_trim = rows[i].cp;
			chan_sets = {4{rows[i].ir, 21'h000000}};
			cyc(3);
			chk({band_div_q, vco_mult_q}, {rows[i].dv, rows[i].ml});
			chk(chips_per_bit_q, rows[i].nrz ? 2'h1 : 2'h2);
			chk(loop_res_sel_q, rows[i].tr);
			chk({int_range_ok_q, trim_pair_ok_q}, {rows[i].ok, rows[i].pr});
		end
		cal(FPC_BAND_315, 9'h000, 4'hF, 9'h002, 9'h004);
		cal(FPC_BAND_915, 9'h1FF, 4'h0, 9'h000, 9'h002);
		chan_sets = {7'h17, 21'h0, 7'h16, 21'h0, 7'h15, 21'h0, 7'h14, 21'h0};
		band_select = FPC_BAND_434;
		// Stop in the same cycle as the command loses
		tx_cmd_valid = 1'b1;
		tx_cmd_channel = 2'h2;
		tx_stop = 1'b1;
		cyc(1);
		tx_cmd_valid = 1'b0;
		tx_stop = 1'b0;
		cyc(2);
		chk({rf_tx_en_q, active_channel_q}, 3'h6);
		chk(cal_target_hint_q, 9'h0B0);
		tx_stop = 1'b1;
		cyc(1);
		tx_stop = 1'b0;
		cyc(1);
		chk(rf_tx_en_q, 1'h0);
		synth_enable = 1'b0;
		cyc(2);
		chk(mmd_ratio_q, 8'h16);
		// Command before calibration has finished
		synth_enable = 1'b1;
		tx_cmd_valid = 1'b1;
		tx_cmd_channel = 2'h1;
		cyc(1);
		tx_cmd_valid = 1'b0;
		cyc(3);
		chk({rf_tx_en_q, cal_busy_q}, 2'h1);
		wait_done();
		cyc(2);
		chk({rf_tx_en_q, active_channel_q}, 3'h5);
		chan_sets[1].frac_ratio = 21'h100000;
		cyc(2);
		k = 0;
		repeat (64)
		begin
			cyc(1);
			k += (mmd_ratio_q === 8'h16);
		end
		chk(k >= 31 && k <= 33, 1'h1);
		// Abort in mid-count, then a reset in mid-count
		synth_enable = 1'b0;
		cyc(1);
		synth_enable = 1'b1;
		cyc(20);
		synth_enable = 1'b0;
		cyc(1);
		chk({cal_busy_q, cal_done_q, cal_fixed_tune_q, vco_cap_code_q}, {3'h0, CAP_RST});
		cyc(1);
		synth_enable = 1'b1;
		cyc(20);
		rst_n = 1'b0;
		cyc(3);
		chk({cal_busy_q, cal_done_q, rf_tx_en_q, vco_cap_code_q, mmd_ratio_q},
			{3'h0, CAP_RST, 1'b0, INT_RST});
		rst_n = 1'b1;
		cyc(3);
		chk(cal_busy_q, 1'h1);
		wait_done();
		chk({cal_done_q, vco_cap_code_q}, 5'h10);
		summarize();
	end
endmodule
